// ---- gpcn_map.svh ----
/*
 * Register offsets, field widths, reset values and key codes of the
 * general purpose pin port with change notification.
 * Assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register.
 */
`ifndef GPCN_MAP_SVH
`define GPCN_MAP_SVH

// Pin counts
`define GPCN_NPINS        26
`define GPCN_NWATCH       21
`define GPCN_NWATCH_LO    16
`define GPCN_NWATCH_HI    5

// Register byte offsets
`define GPCN_OFF_DIR      8'h00
`define GPCN_OFF_LATCH    8'h04
`define GPCN_OFF_PORT     8'h08
`define GPCN_OFF_ODSEL    8'h0c
`define GPCN_OFF_ANALOG   8'h10
`define GPCN_OFF_CNEN_LO  8'h14
`define GPCN_OFF_CNEN_HI  8'h18
`define GPCN_OFF_PU_LO    8'h1c
`define GPCN_OFF_PU_HI    8'h20
`define GPCN_OFF_STATUS   8'h24
`define GPCN_OFF_MASK     8'h28
`define GPCN_OFF_LOCK     8'h2c
`define GPCN_OFF_REMAP    8'h30

// Reset values
`define GPCN_DIR_RST      26'h3ffffff
`define GPCN_LOCK_RST     1'h1

// Status bit positions
`define GPCN_ST_CHANGE    0
`define GPCN_ST_WAKE      1
`define GPCN_NSTAT        2

// Unlock keys written in the low byte of the lock register
`define GPCN_KEY1         8'h46
`define GPCN_KEY2         8'h57

// AXI responses
`define GPCN_RESP_OKAY    2'h0
`define GPCN_RESP_SLVERR  2'h2

`endif

// ---- gpcn_pkg.sv ----
/*
 * Types of the pin port: lock sequencer states and pad drive bundle.
 * Assumes gpcn_map.svh for widths.
 */
`include "gpcn_map.svh"

package gpcn_pkg;

   // Remap lock sequencer, one-hot
   typedef enum logic [2:0] {
      GPCN_LK_IDLE = 3'h1,
      GPCN_LK_KEY1 = 3'h2,
      GPCN_LK_OPEN = 3'h4
   } gpcn_lock_st_t;

   // Drive of every pad, registered together
   typedef struct packed {
      logic [`GPCN_NPINS-1:0] out;
      logic [`GPCN_NPINS-1:0] oe_n;
   } gpcn_pad_t;

endpackage

// ---- gpcn_top.sv ----
/*
 * General purpose pin port: direction, output latch, open-drain select,
 * analog configuration, change notification with interrupt and wake,
 * weak pull-up enables and a lockable remap select, behind AXI4-Lite.
 * Assumes pad inputs synchronous to clk and an outside pad cell that
 * resolves out/oe_n and applies the pull-up current.
 */
// Added by the designer: the AXI4-Lite register port and the address map.
// Function
// [R1] Open-drain pins only pull low
// [R2] Software sets analog pins as inputs
// [R3] Analog output pin converts own level
// [R4] Analog pins read zero in port
// [R5] Write shows in read next cycle; the pin sample behind port reads gets it two edges later
// [R6] Selected pin change raises interrupt
// [R7] Change detection wakes from sleep
// [R8] Up to 21 watched inputs
// [R9] Per-pin enable across two registers
// [R10] Per-pin pull-up across two registers
// [R11] Software disables pull-up on outputs
// [R12] Remap select over 26 pins
// [R13] Lock blocks spurious remap changes
// [R14] Direction one is input, reset input
// [R15] Latch reads latch, port reads pins
// [R16] Compare synced level with last level
`timescale 1ns/1ns
`include "gpcn_map.svh"

module gpcn_top
   import gpcn_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   sleep_mode,
   input  wire logic [`GPCN_NPINS-1:0] pad_in,
   input  wire logic [`GPCN_NPINS-1:0] periph_out,
   output logic [`GPCN_NPINS-1:0]      pad_out,
   output logic [`GPCN_NPINS-1:0]      pad_oe_n,
   output logic [`GPCN_NWATCH-1:0]     pad_pullup_en,
   output logic [`GPCN_NPINS-1:0]      adc_level,
   output logic                        irq,
   output logic                        wake
);

   localparam int N = `GPCN_NPINS;
   localparam int W = `GPCN_NWATCH;

   // Software visible state
   logic [N-1:0]              direction_select_q;  // 1 = input
   logic [N-1:0]              output_latch_q;
   logic [N-1:0]              open_drain_select_q;
   logic [N-1:0]              analog_pin_config_q;
   logic [`GPCN_NWATCH_LO-1:0] change_irq_enable_lo_q;
   logic [`GPCN_NWATCH_HI-1:0] change_irq_enable_hi_q;
   logic [`GPCN_NWATCH_LO-1:0] weak_pullup_enable_lo_q;
   logic [`GPCN_NWATCH_HI-1:0] weak_pullup_enable_hi_q;
   logic [`GPCN_NSTAT-1:0]    status_q;            // Sticky events
   logic [`GPCN_NSTAT-1:0]    mask_q;              // 1 = enabled
   logic [N-1:0]              remap_sel_q;         // 1 = peripheral owns
   logic                      lock_q;              // Remap locked
   gpcn_lock_st_t             lock_st_q;

   // Pin sampling and change detection
   logic [N-1:0]              pin_q;               // Sampled pad levels
   logic [W-1:0]              last_q;              // Previous levels
   logic [W-1:0]              watch_en;            // Joined enables
   logic [W-1:0]              hit;                 // Per-pin change
   gpcn_pad_t                 pad_d;
   gpcn_pad_t                 pad_q;

   // Bus slave state
   logic                      aw_full_q;
   logic                      w_full_q;
   logic [7:0]                awaddr_q;
   logic [31:0]               wdata_q;
   logic [3:0]                wstrb_q;
   logic                      awready_q;
   logic                      wready_q;
   logic                      bvalid_q;
   logic [1:0]                bresp_q;
   logic                      arready_q;
   logic                      rvalid_q;
   logic [1:0]                rresp_q;
   logic [31:0]               rdata_q;
   logic [31:0]               rdata_d;
   logic                      rhit_d;
   logic                      whit_d;
   logic                      wr_do;
   logic [31:0]               wval;
   logic                      irq_q;
   logic                      wake_q;

   // Handshakes
   wire aw_take = s_axi_awvalid & awready_q;
   wire w_take  = s_axi_wvalid & wready_q;
   wire ar_take = s_axi_arvalid & arready_q;
   assign wr_do = aw_full_q & w_full_q & ~bvalid_q;

   // Byte-lane merge of write data over an old register value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Per-register write value, lanes merged with zero-extended old value
   always_comb begin
      wval = merge(32'h0, wdata_q, wstrb_q);
      unique case (awaddr_q)
         `GPCN_OFF_DIR:     wval = merge(32'(direction_select_q),
                                         wdata_q, wstrb_q);
         `GPCN_OFF_LATCH,
         `GPCN_OFF_PORT:    wval = merge(32'(output_latch_q),
                                         wdata_q, wstrb_q);
         `GPCN_OFF_ODSEL:   wval = merge(32'(open_drain_select_q),
                                         wdata_q, wstrb_q);
         `GPCN_OFF_ANALOG:  wval = merge(32'(analog_pin_config_q),
                                         wdata_q, wstrb_q);
         `GPCN_OFF_CNEN_LO: wval = merge(32'(change_irq_enable_lo_q),
                                         wdata_q, wstrb_q);
         `GPCN_OFF_CNEN_HI: wval = merge(32'(change_irq_enable_hi_q),
                                         wdata_q, wstrb_q);
         `GPCN_OFF_PU_LO:   wval = merge(32'(weak_pullup_enable_lo_q),
                                         wdata_q, wstrb_q);
         `GPCN_OFF_PU_HI:   wval = merge(32'(weak_pullup_enable_hi_q),
                                         wdata_q, wstrb_q);
         `GPCN_OFF_MASK:    wval = merge(32'(mask_q), wdata_q, wstrb_q);
         `GPCN_OFF_REMAP:   wval = merge(32'(remap_sel_q),
                                         wdata_q, wstrb_q);
         default:           wval = merge(32'h0, wdata_q, wstrb_q);
      endcase
   end

   // Write address and data held until both are in
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
      end else begin
         if (aw_take) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
            awready_q <= 1'b0;
         end else if (wr_do) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b1;
         end
         if (w_take) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            wready_q <= 1'b0;
         end else if (wr_do) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b1;
         end
      end
   end

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `GPCN_RESP_OKAY;
      end else if (wr_do) begin
         bvalid_q <= 1'b1;
         bresp_q  <= whit_d ? `GPCN_RESP_OKAY : `GPCN_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign whit_d = (awaddr_q <= `GPCN_OFF_REMAP);

   // Configuration registers; port writes land in the latch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         direction_select_q      <= `GPCN_DIR_RST;  // [R14]
         output_latch_q          <= '0;
         open_drain_select_q     <= '0;
         analog_pin_config_q     <= '0;
         change_irq_enable_lo_q  <= '0;
         change_irq_enable_hi_q  <= '0;
         weak_pullup_enable_lo_q <= '0;
         weak_pullup_enable_hi_q <= '0;
         mask_q                  <= '0;
      end else if (wr_do) begin
         unique case (awaddr_q)
            `GPCN_OFF_DIR:     direction_select_q <= wval[N-1:0];
            `GPCN_OFF_LATCH,
            `GPCN_OFF_PORT:    output_latch_q <= wval[N-1:0];  // [R15]
            `GPCN_OFF_ODSEL:   open_drain_select_q <= wval[N-1:0];
            `GPCN_OFF_ANALOG:  analog_pin_config_q <= wval[N-1:0];
            `GPCN_OFF_CNEN_LO: change_irq_enable_lo_q <=
                                  wval[`GPCN_NWATCH_LO-1:0];  // [R9]
            `GPCN_OFF_CNEN_HI: change_irq_enable_hi_q <=
                                  wval[`GPCN_NWATCH_HI-1:0];  // [R9]
            `GPCN_OFF_PU_LO:   weak_pullup_enable_lo_q <=
                                  wval[`GPCN_NWATCH_LO-1:0];  // [R10]
            `GPCN_OFF_PU_HI:   weak_pullup_enable_hi_q <=
                                  wval[`GPCN_NWATCH_HI-1:0];  // [R10]
            `GPCN_OFF_MASK:    mask_q <= wval[`GPCN_NSTAT-1:0];
            default:           ;  // Other offsets handled elsewhere
         endcase
      end
   end

   // Remap lock: two keys, then the next lock write sets or clears it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_q    <= `GPCN_LOCK_RST;
         lock_st_q <= GPCN_LK_IDLE;
      end else if (wr_do && awaddr_q == `GPCN_OFF_LOCK) begin
         unique case (lock_st_q)
            GPCN_LK_IDLE: lock_st_q <= (wval[7:0] == `GPCN_KEY1) ?
                                       GPCN_LK_KEY1 : GPCN_LK_IDLE;
            GPCN_LK_KEY1: lock_st_q <= (wval[7:0] == `GPCN_KEY2) ?
                                       GPCN_LK_OPEN : GPCN_LK_IDLE;
            GPCN_LK_OPEN: begin
               lock_q    <= wval[0];  // [R13]
               lock_st_q <= GPCN_LK_IDLE;
            end
            default:      lock_st_q <= GPCN_LK_IDLE;
         endcase
      end else if (wr_do) begin
         lock_st_q <= GPCN_LK_IDLE;  // Any other write breaks the keys
      end
   end

   // Remap select; a locked write completes but changes nothing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remap_sel_q <= '0;
      end else if (wr_do && awaddr_q == `GPCN_OFF_REMAP && !lock_q) begin
         remap_sel_q <= wval[N-1:0];  // [R12] [R13]
      end
   end

   // Pin sampling; pad drive is registered, so a write or direction
   // change reaches this sample two edges later, not on the next read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_q  <= '0;
         last_q <= '0;
      end else begin
         pin_q  <= pad_in;               // [R5] [R15]
         last_q <= pin_q[W-1:0];         // [R16]
      end
   end

   assign watch_en = {change_irq_enable_hi_q, change_irq_enable_lo_q};

   // Per-pin drive and per-watched-pin change compare
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_pin
         wire drv  = ~direction_select_q[gi];            // [R14]
         wire data = remap_sel_q[gi] ? periph_out[gi]
                                     : output_latch_q[gi];
         // Open drain never drives high, only sinks or floats
         assign pad_d.out[gi]  = open_drain_select_q[gi] ? 1'b0
                                                        : data;  // [R1]
         assign pad_d.oe_n[gi] = open_drain_select_q[gi] ?
                                 ~(drv & ~data) : ~drv;          // [R1]
         if (gi < W) begin : g_watch
            assign hit[gi] = watch_en[gi] &
                             (pin_q[gi] ^ last_q[gi]);  // [R8] [R16]
         end
      end
   endgenerate

   // Pad, pull-up and converter outputs straight from flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_q         <= '{out: '0, oe_n: '1};
         pad_pullup_en <= '0;
         adc_level     <= '0;
      end else begin
         pad_q         <= pad_d;
         pad_pullup_en <= {weak_pullup_enable_hi_q,
                           weak_pullup_enable_lo_q};  // [R10]
         // Analog pin left as output converts its own driven level
         adc_level     <= (analog_pin_config_q & ~direction_select_q &
                           pad_q.out) |
                          (pad_in & ~(analog_pin_config_q &
                                      ~direction_select_q));  // [R3]
      end
   end

   assign pad_out  = pad_q.out;
   assign pad_oe_n = pad_q.oe_n;

   // Sticky status: a new event wins over a same-cycle clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= '0;
      end else begin
         for (int b = 0; b < `GPCN_NSTAT; b++) begin
            if (wr_do && awaddr_q == `GPCN_OFF_STATUS && wval[b]) begin
               status_q[b] <= 1'b0;
            end
         end
         if (|hit) begin
            status_q[`GPCN_ST_CHANGE] <= 1'b1;  // [R6] [R9]
         end
         if (|hit && sleep_mode) begin
            status_q[`GPCN_ST_WAKE] <= 1'b1;    // [R7]
         end
      end
   end

   // Interrupt and wake levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q  <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         irq_q  <= |(status_q & mask_q);  // [R6]
         // Detection clock keeps running while the core sleeps
         wake_q <= sleep_mode & (|hit | wake_q);  // [R7]
      end
   end

   assign irq  = irq_q;
   assign wake = wake_q;

   // Read mux; port read hides analog pins as low
   always_comb begin
      rdata_d = 32'h0;
      rhit_d  = 1'b1;
      unique case ({s_axi_araddr[7:2], 2'b00})
         `GPCN_OFF_DIR:     rdata_d = 32'(direction_select_q);
         `GPCN_OFF_LATCH:   rdata_d = 32'(output_latch_q);      // [R15]
         `GPCN_OFF_PORT:    rdata_d = 32'(pin_q &
                                          ~analog_pin_config_q); // [R4]
         `GPCN_OFF_ODSEL:   rdata_d = 32'(open_drain_select_q);
         `GPCN_OFF_ANALOG:  rdata_d = 32'(analog_pin_config_q);
         `GPCN_OFF_CNEN_LO: rdata_d = 32'(change_irq_enable_lo_q);
         `GPCN_OFF_CNEN_HI: rdata_d = 32'(change_irq_enable_hi_q);
         `GPCN_OFF_PU_LO:   rdata_d = 32'(weak_pullup_enable_lo_q);
         `GPCN_OFF_PU_HI:   rdata_d = 32'(weak_pullup_enable_hi_q);
         `GPCN_OFF_STATUS:  rdata_d = 32'(status_q);
         `GPCN_OFF_MASK:    rdata_d = 32'(mask_q);
         `GPCN_OFF_LOCK:    rdata_d = 32'(lock_q);
         `GPCN_OFF_REMAP:   rdata_d = 32'(remap_sel_q);
         default:           rhit_d  = 1'b0;
      endcase
   end

   // Read channel, one read at a time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= `GPCN_RESP_OKAY;
      end else if (ar_take) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rdata_d;
         rresp_q   <= rhit_d ? `GPCN_RESP_OKAY : `GPCN_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

endmodule

// ---- gpcn_props.sv ----
/*
 * Checker of the pin port: bus answers, pad drive after reset,
 * converter source selection and sleep wake behaviour.
 * Assumes it is bound to gpcn_top and sees only its ports.
 */
`timescale 1ns/1ns

module gpcn_props
   import gpcn_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        sleep_mode,
   input wire logic [25:0] pad_in,
   input wire logic [25:0] periph_out,
   input wire logic [25:0] pad_out,
   input wire logic [25:0] pad_oe_n,
   input wire logic [20:0] pad_pullup_en,
   input wire logic [25:0] adc_level,
   input wire logic        irq,
   input wire logic        wake
);
   // One clock domain, one reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Both write channels taken at one edge
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Read address taken
   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   property p_rst_in;
      $rose(rst_n) |-> &pad_oe_n;
   endproperty
   // Each converter bit follows its pad or its own driven level
   property p_adc_src;
      $past(rst_n) |->
         ((adc_level ^ $past(pad_in)) & (adc_level ^ $past(pad_out))) == '0;
   endproperty
   property p_wake_clr;
      !sleep_mode |=> !wake;
   endproperty
   property p_wake_set;
      $rose(wake) |-> $past(sleep_mode);
   endproperty
   property p_rd_ans;
      s_ar_take |=> s_axi_rvalid;
   endproperty
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_wr_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_wr_ans;
      s_wr_take ##1 !s_axi_bvalid |=> s_axi_bvalid;
   endproperty

   a_rst_in: assert property (p_rst_in)
      else $error("pins not all inputs after reset");
   a_adc_src: assert property (p_adc_src)
      else $error("converter level from wrong source");
   a_wake_clr: assert property (p_wake_clr)
      else $error("wake held outside sleep");
   a_wake_set: assert property (p_wake_set)
      else $error("wake rose outside sleep");
   a_rd_ans: assert property (p_rd_ans)
      else $error("read answer late");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read answer dropped or changed");
   a_wr_hold: assert property (p_wr_hold)
      else $error("write answer dropped or changed");
   a_wr_ans: assert property (p_wr_ans)
      else $error("write answer late");
endmodule

bind gpcn_top gpcn_props u_props (.*);

// ---- gpcn_pad_model.sv ----
/*
 * Outside circuits on the pads: buttons that drive or release each pin.
 * Assumes design drive wins; a pin nobody holds floats and wanders.
 */
`timescale 1ns/1ns

module gpcn_pad_model (
   input wire logic        clk,
   input wire logic [25:0] pad_out,
   input wire logic [25:0] pad_oe_n,
   input wire logic [20:0] pad_pullup_en,
   input wire logic [25:0] btn_lv,
   input wire logic [25:0] btn_dr,
   output logic [25:0]     pad_in
);
   logic flip = 1'h0; // Floating pin pattern, changes each cycle

   // Undriven level must not look stable to the port
   always @(posedge clk) flip <= ~flip;

   // Resolve each pad: port drive, button, weak pull-up, else float
   always_comb begin
      for (int i = 0; i < 26; i++) begin
         if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
         else if (btn_dr[i]) pad_in[i] = btn_lv[i];
         else if (i < 21 && pad_pullup_en[i]) pad_in[i] = 1'h1;
         else pad_in[i] = flip ^ i[0];
      end
   end
endmodule

// ---- gpcn_top_tb.sv ----
/*
 * Self-checking bench of the pin port over AXI4-Lite.
 * Assumes gpcn_top, gpcn_pad_model and the bound checker.
 */
`timescale 1ns/1ns
`include "gpcn_map.svh"

module gpcn_top_tb;
   import gpcn_pkg::*;
   logic        clk = 1'h0, rst_n = 1'h0, sleep_mode = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0, rv;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  rr;
   wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire logic   s_axi_rvalid, irq, wake;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [25:0] pad_in, pad_out, pad_oe_n, adc_level;
   wire logic [20:0] pad_pullup_en;
   logic [25:0] periph_out = 26'h1, btn_lv = 26'h0, btn_dr = '1;
   int          n_fail = 0, n_tests = 0;

   always #20 clk = ~clk; // 25 MHz

   gpcn_top DUT (.*);
   gpcn_pad_model u_pads (.clk(clk), .pad_out(pad_out),
      .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
      .btn_lv(btn_lv), .btn_dr(btn_dr), .pad_in(pad_in));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Answer held back a cycle so the slave must keep it standing
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = 2'h0);
      @(posedge clk);
      s_axi_awaddr <= a; s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
      do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'h0; s_axi_wvalid <= 1'h0;
      repeat (2) @(posedge clk);
      s_axi_bready <= 1'h1;
      do @(posedge clk); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, er);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er = 2'h0);
      @(posedge clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'h1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      @(posedge clk);
      s_axi_rready <= 1'h1;
      do @(posedge clk); while (s_axi_rvalid !== 1'h1);
      rv = s_axi_rdata; rr = s_axi_rresp;
      s_axi_rready <= 1'h0;
      chk(rv, exp);
      chk(rr, er);
   endtask

   task automatic t_reset;
      chk(pad_oe_n, 32'h3ffffff);
      rdc(`GPCN_OFF_DIR, 32'h3ffffff);
      rdc(`GPCN_OFF_LOCK, 32'h1);
   endtask

   task automatic t_pins;
      @(posedge clk) btn_dr <= '0;
      wr(`GPCN_OFF_DIR, 32'h0);
      wr(`GPCN_OFF_LATCH, 32'h2aaaaaa);
      chk(pad_oe_n, 32'h0);
      chk(pad_out, 32'h2aaaaaa);
      rdc(`GPCN_OFF_PORT, 32'h2aaaaaa);
      wr(`GPCN_OFF_PORT, 32'h1555555);
      rdc(`GPCN_OFF_LATCH, 32'h1555555);
      wr(`GPCN_OFF_ODSEL, 32'h3);
      chk({pad_oe_n[1:0], pad_out[1:0]}, 32'h4);
      wr(`GPCN_OFF_ODSEL, 32'h0);
      @(posedge clk) btn_dr <= '1;
      wr(`GPCN_OFF_DIR, 32'h3ffffff);
   endtask

   task automatic t_analog;
      @(posedge clk) btn_lv <= '1;
      wr(`GPCN_OFF_ANALOG, 32'h2);
      rdc(`GPCN_OFF_PORT, 32'h3fffffd);
      chk(adc_level[1], 32'h1);
      @(posedge clk) btn_dr <= ~26'h2;
      wr(`GPCN_OFF_LATCH, 32'h0);
      wr(`GPCN_OFF_DIR, 32'h3fffffd);
      chk(adc_level[1], 32'h0);
      wr(`GPCN_OFF_DIR, 32'h3ffffff);
      @(posedge clk) btn_dr <= '1;
      wr(`GPCN_OFF_ANALOG, 32'h0);
   endtask

   task automatic t_change;
      wr(`GPCN_OFF_CNEN_HI, 32'hffffffff);
      rdc(`GPCN_OFF_CNEN_HI, 32'h1f);
      wr(`GPCN_OFF_MASK, 32'h1);
      wr(`GPCN_OFF_STATUS, 32'h3);
      // Unwatched pin 21 and disabled pin 0 must stay quiet
      @(posedge clk) btn_lv <= btn_lv & ~26'h200001;
      repeat (4) @(posedge clk);
      chk(irq, 32'h0);
      @(posedge clk) btn_lv[20] <= 1'h0;
      repeat (4) @(posedge clk);
      chk(irq, 32'h1);
      rdc(`GPCN_OFF_STATUS, 32'h1);
      wr(`GPCN_OFF_STATUS, 32'h1);
      chk(irq, 32'h0);
      wr(`GPCN_OFF_MASK, 32'h0);
      @(posedge clk) btn_lv[20] <= 1'h1;
      repeat (4) @(posedge clk);
      chk(irq, 32'h0);
      rdc(`GPCN_OFF_STATUS, 32'h1);
      wr(`GPCN_OFF_STATUS, 32'h1);
      wr(`GPCN_OFF_MASK, 32'h1);
   endtask

   task automatic t_sleep;
      @(posedge clk);
      sleep_mode <= 1'h1;
      btn_lv[20] <= 1'h0;
      repeat (4) @(posedge clk);
      chk(wake, 32'h1);
      rdc(`GPCN_OFF_STATUS, 32'h3);
      @(posedge clk) sleep_mode <= 1'h0;
      repeat (2) @(posedge clk);
      chk(wake, 32'h0);
      wr(`GPCN_OFF_STATUS, 32'h3);
   endtask

   task automatic t_remap;
      wr(`GPCN_OFF_REMAP, 32'h1);
      rdc(`GPCN_OFF_REMAP, 32'h0);
      wr(`GPCN_OFF_LOCK, 32'h46);
      wr(`GPCN_OFF_LOCK, 32'h57);
      wr(`GPCN_OFF_LOCK, 32'h0);
      rdc(`GPCN_OFF_LOCK, 32'h0);
      wr(`GPCN_OFF_REMAP, 32'h1);
      rdc(`GPCN_OFF_REMAP, 32'h1);
      @(posedge clk) btn_dr <= ~26'h1;
      wr(`GPCN_OFF_DIR, 32'h3fffffe);
      chk(pad_out[0], 32'h1);
      wr(`GPCN_OFF_LOCK, 32'h46);
      wr(`GPCN_OFF_LOCK, 32'h57);
      wr(`GPCN_OFF_LOCK, 32'h1);
      wr(`GPCN_OFF_REMAP, 32'h0);
      rdc(`GPCN_OFF_REMAP, 32'h1);
      wr(`GPCN_OFF_DIR, 32'h3ffffff);
      @(posedge clk) btn_dr <= '1;
   endtask

   task automatic t_pullup;
      wr(`GPCN_OFF_PU_LO, 32'h8001);
      wr(`GPCN_OFF_PU_HI, 32'h10);
      chk(pad_pullup_en, 32'h108001);
      @(posedge clk) btn_dr <= ~26'h1;
      rdc(`GPCN_OFF_PORT, 32'h3cfffff);
      @(posedge clk) btn_dr <= '1;
      wr(`GPCN_OFF_PU_LO, 32'h0);
   endtask

   task automatic t_bad;
      wr(8'h34, 32'h1, `GPCN_RESP_SLVERR);
      rdc(8'h34, 32'h0, `GPCN_RESP_SLVERR);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      close_out();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      t_reset();
      t_pins();
      t_analog();
      t_change();
      t_sleep();
      t_remap();
      t_pullup();
      t_bad();
      close_out();
   end
endmodule
